//--- rtl/probe_latch_map.svh
// Register indices, field positions and reset values of the probe latch block.
// Assumes byte address = index * 4 on a 32-bit APB bus.
`ifndef PROBE_LATCH_MAP_SVH
`define PROBE_LATCH_MAP_SVH

`define PLC_ADDR_W     18
`define PLC_DATA_W     32
`define PLC_IDX_W      16
`define PLC_IDX_CTRL   16'h60b8
`define PLC_IDX_STAT   16'h60b9
`define PLC_IDX_P1_RISE 16'h60ba
`define PLC_IDX_P1_FALL 16'h60bb
`define PLC_IDX_P2_RISE 16'h60bc
`define PLC_IDX_P2_FALL 16'h60bd
`define PLC_IDX_IRQ_ST 16'h60c0
`define PLC_IDX_IRQ_MSK 16'h60c1

`define PLC_CTRL_W     16
`define PLC_CTRL_RST   16'h0000
`define PLC_P1_EN_BIT  0
`define PLC_POS_W      32
`define PLC_POS_RST    32'h0000_0000
`define PLC_NEV        4
`define PLC_EV_RST     4'h0
`define PLC_IN_W       3
`define PLC_IN_ZERO    2

`endif

//--- rtl/probe_latch_pkg.sv
// Types shared by the probe latch block.
// Assumes probe_latch_map.svh for numeric constants.
package probe_latch_pkg;

    // One probe's control byte, bit 0 at the bottom
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic       fall_arm;
        logic       rise_arm;
        logic       rsv_lo;
        logic       src;
        logic       cont;
        logic       en;
    } probe_cfg_t;

    // One probe's status byte
    typedef struct packed {
        logic       toggle;
        logic [3:0] rsv;
        logic       fall_st;
        logic       rise_st;
        logic       en;
    } probe_stat_t;

endpackage : probe_latch_pkg

//--- rtl/touch_probe_latch_control.sv
// Two-probe position latch with APB register access and one interrupt.
// Assumes POSITION and HOMING_ACTIVE come from CORE_CLK logic; probe and zero-pulse inputs are asynchronous pins.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "probe_latch_map.svh"

module touch_probe_latch_control
    import probe_latch_pkg::*;
(
    input  wire logic                     CORE_CLK,
    input  wire logic                     RST,
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [`PLC_ADDR_W-1:0]   PADDR,
    input  wire logic [`PLC_DATA_W-1:0]   PWDATA,
    input  wire logic [3:0]               PSTRB,
    output logic      [`PLC_DATA_W-1:0]   PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR,
    input  wire logic                     PROBE_ONE_INPUT,
    input  wire logic                     PROBE_TWO_INPUT,
    input  wire logic                     ENC_ZERO_PULSE,
    input  wire logic                     HOMING_ACTIVE,
    input  wire logic [`PLC_POS_W-1:0]    POSITION,
    output logic                          IRQ
);

    logic [`PLC_CTRL_W-1:0] ctrl_r;
    logic [`PLC_CTRL_W-1:0] ctrl_nxt;
    logic [`PLC_NEV-1:0]    irq_st_r;
    logic [`PLC_NEV-1:0]    irq_st_nxt;
    logic [`PLC_NEV-1:0]    irq_msk_r;
    logic [`PLC_NEV-1:0]    irq_msk_nxt;
    logic [`PLC_DATA_W-1:0] prdata_r;
    logic [`PLC_DATA_W-1:0] prdata_nxt;
    logic                   pready_r;
    logic                   pready_nxt;
    logic                   pslverr_r;
    logic                   pslverr_nxt;
    logic                   irq_r;
    logic                   irq_nxt;
    logic                   homing_q_r;
    logic                   homing_q_nxt;
    logic [`PLC_IN_W-1:0]   meta_r;
    logic [`PLC_IN_W-1:0]   meta_nxt;
    logic [`PLC_IN_W-1:0]   sync_r;
    logic [`PLC_IN_W-1:0]   sync_nxt;
    logic [`PLC_IN_W-1:0]   prev_r;
    logic [`PLC_IN_W-1:0]   prev_nxt;

    logic [`PLC_POS_W-1:0]  cap_pos [`PLC_NEV];
    probe_stat_t            st_byte [2];
    logic [`PLC_NEV-1:0]    ev;
    logic [`PLC_IDX_W-1:0]  idx;
    logic                   aligned;
    logic                   acc_phase;
    logic                   commit;
    logic                   wr;
    logic                   hit;
    logic [`PLC_DATA_W-1:0] rd_val;
    logic                   homing_start;

    assign idx          = PADDR[`PLC_ADDR_W-1:2];
    assign aligned      = (PADDR[1:0] == 2'h0);
    assign acc_phase    = PSEL & PENABLE;
    assign commit       = acc_phase & pready_r;
    assign wr           = commit & PWRITE;
    assign homing_start = HOMING_ACTIVE & ~homing_q_r;

    // Read data and address decode
    always_comb begin
        rd_val = '0;
        hit    = aligned;
        case (idx)
            `PLC_IDX_CTRL:    rd_val = {16'h0000, ctrl_r};
            `PLC_IDX_STAT:    rd_val = {16'h0000, st_byte[1], st_byte[0]};
            `PLC_IDX_P1_RISE: rd_val = cap_pos[0];
            `PLC_IDX_P1_FALL: rd_val = cap_pos[1];
            `PLC_IDX_P2_RISE: rd_val = cap_pos[2];
            `PLC_IDX_P2_FALL: rd_val = cap_pos[3];
            `PLC_IDX_IRQ_ST:  rd_val = {28'h0000000, irq_st_r};
            `PLC_IDX_IRQ_MSK: rd_val = {28'h0000000, irq_msk_r};
            default:          hit    = 1'b0;
        endcase
    end

    // Bus, control word and interrupt next values
    always_comb begin
        ctrl_nxt     = ctrl_r;
        irq_st_nxt   = irq_st_r;
        irq_msk_nxt  = irq_msk_r;
        prdata_nxt   = prdata_r;
        pslverr_nxt  = 1'b0;
        pready_nxt   = acc_phase & ~pready_r;
        homing_q_nxt = HOMING_ACTIVE;
        meta_nxt     = {ENC_ZERO_PULSE, PROBE_TWO_INPUT, PROBE_ONE_INPUT};
        sync_nxt     = meta_r;
        prev_nxt     = sync_r;
        if (acc_phase && !pready_r) begin
            prdata_nxt  = PWRITE ? '0 : rd_val;
            pslverr_nxt = ~hit;
        end
        if (wr && hit && idx == `PLC_IDX_CTRL) begin
            // Full 16-bit range accepted; reserved bits stored but unused
            if (PSTRB[0]) begin
                ctrl_nxt[7:0] = PWDATA[7:0];
            end
            if (PSTRB[1]) begin
                ctrl_nxt[15:8] = PWDATA[15:8];
            end
        end
        if (homing_start) begin
            ctrl_nxt[`PLC_P1_EN_BIT] = 1'b0;
        end
        if (wr && hit && idx == `PLC_IDX_IRQ_ST && PSTRB[0]) begin
            irq_st_nxt = irq_st_nxt & ~PWDATA[`PLC_NEV-1:0];
        end
        if (wr && hit && idx == `PLC_IDX_IRQ_MSK && PSTRB[0]) begin
            irq_msk_nxt = PWDATA[`PLC_NEV-1:0];
        end
        // A new capture wins over a clear in the same cycle
        irq_st_nxt = irq_st_nxt | ev;
        irq_nxt    = |(irq_st_r & irq_msk_r);
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_r     <= `PLC_CTRL_RST;
            irq_st_r   <= `PLC_EV_RST;
            irq_msk_r  <= `PLC_EV_RST;
            prdata_r   <= '0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            irq_r      <= 1'b0;
            homing_q_r <= 1'b0;
            meta_r     <= '0;
            sync_r     <= '0;
            prev_r     <= '0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            irq_st_r   <= irq_st_nxt;
            irq_msk_r  <= irq_msk_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            irq_r      <= irq_nxt;
            homing_q_r <= homing_q_nxt;
            meta_r     <= meta_nxt;
            sync_r     <= sync_nxt;
            prev_r     <= prev_nxt;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_probe
        probe_cfg_t            cfg;
        logic                  en_eff;
        logic                  live;
        logic                  sig;
        logic                  sig_prev;
        logic                  rise_ev;
        logic                  fall_ev;
        logic                  start;
        logic                  src_r;
        logic                  src_nxt;
        logic                  en_prev_r;
        logic                  en_prev_nxt;
        logic                  rise_st_r;
        logic                  rise_st_nxt;
        logic                  fall_st_r;
        logic                  fall_st_nxt;
        logic                  tog_r;
        logic                  tog_nxt;
        logic [`PLC_POS_W-1:0] rise_pos_r;
        logic [`PLC_POS_W-1:0] rise_pos_nxt;
        logic [`PLC_POS_W-1:0] fall_pos_r;
        logic [`PLC_POS_W-1:0] fall_pos_nxt;

        assign cfg      = probe_cfg_t'(ctrl_r[8*i +: 8]);
        assign en_eff   = cfg.en & ~((i == 0) & HOMING_ACTIVE);
        assign start    = en_eff & ~en_prev_r;
        // Events wait one cycle after enable so the source is loaded first
        assign live     = en_eff & en_prev_r;
        assign sig      = src_r ? sync_r[`PLC_IN_ZERO] : sync_r[i];
        assign sig_prev = src_r ? prev_r[`PLC_IN_ZERO] : prev_r[i];
        assign rise_ev  = live & cfg.rise_arm & sig & ~sig_prev
                          & (cfg.cont | ~rise_st_r);
        assign fall_ev  = live & cfg.fall_arm & ~sig & sig_prev
                          & (cfg.cont | ~fall_st_r);

        always_comb begin
            src_nxt      = src_r;
            en_prev_nxt  = en_eff;
            rise_st_nxt  = rise_st_r;
            fall_st_nxt  = fall_st_r;
            tog_nxt      = tog_r;
            rise_pos_nxt = rise_pos_r;
            fall_pos_nxt = fall_pos_r;
            // Source sampled at enable and at each restart in continuous mode
            if (start || (cfg.cont && (rise_ev || fall_ev))) begin
                src_nxt = cfg.src;
            end
            if (rise_ev) begin
                rise_pos_nxt = POSITION;
                rise_st_nxt  = 1'b1;
            end
            if (fall_ev) begin
                fall_pos_nxt = POSITION;
                fall_st_nxt  = 1'b1;
            end
            if (cfg.cont && (rise_ev || fall_ev)) begin
                tog_nxt = ~tog_r;
            end
            if (!en_eff || !cfg.rise_arm) begin
                rise_st_nxt = 1'b0;
            end
            if (!en_eff || !cfg.fall_arm) begin
                fall_st_nxt = 1'b0;
            end
        end

        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                src_r      <= 1'b0;
                en_prev_r  <= 1'b0;
                rise_st_r  <= 1'b0;
                fall_st_r  <= 1'b0;
                tog_r      <= 1'b0;
                rise_pos_r <= `PLC_POS_RST;
                fall_pos_r <= `PLC_POS_RST;
            end else begin
                src_r      <= src_nxt;
                en_prev_r  <= en_prev_nxt;
                rise_st_r  <= rise_st_nxt;
                fall_st_r  <= fall_st_nxt;
                tog_r      <= tog_nxt;
                rise_pos_r <= rise_pos_nxt;
                fall_pos_r <= fall_pos_nxt;
            end
        end

        assign cap_pos[2*i]   = rise_pos_r;
        assign cap_pos[2*i+1] = fall_pos_r;
        assign ev[2*i]        = rise_ev;
        assign ev[2*i+1]      = fall_ev;
        assign st_byte[i]     = '{toggle: tog_r, rsv: 4'h0, fall_st: fall_st_r,
                                  rise_st: rise_st_r, en: en_eff};
    end

    assign PRDATA  = prdata_r;
    assign PREADY  = pready_r;
    assign PSLVERR = pslverr_r;
    assign IRQ     = irq_r;

endmodule : touch_probe_latch_control

//--- bench/touch_probe_latch_control_props.sv
// Checker for the probe latch block: APB timing, error replies, read-back fields, homing and interrupt.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`include "probe_latch_map.svh"

module touch_probe_latch_control_props
    import probe_latch_pkg::*;
(
    input wire logic                   CORE_CLK,
    input wire logic                   RST,
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic                   PWRITE,
    input wire logic [`PLC_ADDR_W-1:0] PADDR,
    input wire logic [`PLC_DATA_W-1:0] PWDATA,
    input wire logic [3:0]             PSTRB,
    input wire logic [`PLC_DATA_W-1:0] PRDATA,
    input wire logic                   PREADY,
    input wire logic                   PSLVERR,
    input wire logic                   PROBE_ONE_INPUT,
    input wire logic                   PROBE_TWO_INPUT,
    input wire logic                   ENC_ZERO_PULSE,
    input wire logic                   HOMING_ACTIVE,
    input wire logic [`PLC_POS_W-1:0]  POSITION,
    input wire logic                   IRQ
);
    logic [15:0] idx;
    logic        mapped;
    logic        rd_ack;

    assign idx = PADDR[17:2];
    assign mapped = PADDR[1:0] == 2'b00 &&
        (idx inside {[`PLC_IDX_CTRL:`PLC_IDX_P2_FALL], `PLC_IDX_IRQ_ST, `PLC_IDX_IRQ_MSK});
    assign rd_ack = PREADY && !PWRITE;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_wait;
        PSEL && PENABLE && !PREADY;
    endsequence

    a_ready_wait: assert property (s_setup ##1 s_wait |=> PREADY)
        else $error("no answer in second access cycle");
    a_ready_place: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
        else $error("ready outside an access phase");
    a_err_unmap: assert property (PREADY && !mapped |-> PSLVERR)
        else $error("unmapped access not refused");
    a_err_none: assert property (PREADY && mapped |-> !PSLVERR)
        else $error("mapped access refused");
    a_ctrl_upper: assert property (rd_ack && idx == `PLC_IDX_CTRL |-> PRDATA[31:16] == 16'h0)
        else $error("control upper half not zero");
    a_stat_rsv: assert property (rd_ack && idx == `PLC_IDX_STAT |-> (PRDATA & 32'hffff_7878) == 32'h0)
        else $error("status reserved bits set");
    a_homing_off: assert property (rd_ack && idx == `PLC_IDX_STAT && HOMING_ACTIVE
        && $past(HOMING_ACTIVE) && $past(HOMING_ACTIVE, 2) |-> !PRDATA[0])
        else $error("probe one enabled during homing");
    a_reset_quiet: assert property ($fell(RST) |-> !IRQ && !PREADY && !PSLVERR && PRDATA == 32'h0)
        else $error("outputs not quiet after reset");
    a_irq_drop: assert property (PREADY && PWRITE && idx == `PLC_IDX_IRQ_MSK && PWDATA[3:0] == 4'h0
        |-> ##[1:3] !IRQ)
        else $error("interrupt stays up with all masked");
endmodule : touch_probe_latch_control_props

//--- bench/pins_model.sv
// Far-side model: probe pins, encoder zero pulse and the position source.
// Assumes calls start on clk; pins idle low.
`timescale 1ns/100ps

module pins_model (
    input  wire logic  clk,
    output logic       probe_one,
    output logic       probe_two,
    output logic       zero_pulse,
    output logic [31:0] position
);
    initial begin
        probe_one = 1'b0;
        probe_two = 1'b0;
        zero_pulse = 1'b0;
        position = 32'h0;
    end

    // Position settles a cycle ahead so the capture sees a steady value
    task automatic move(input int sel, input logic lvl, input logic [31:0] pos);
        @(posedge clk);
        position <= pos;
        @(posedge clk);
        if (sel == 0) probe_one <= lvl;
        else if (sel == 1) probe_two <= lvl;
        else zero_pulse <= lvl;
        // Level held well past the two-cycle minimum
        repeat (8) @(posedge clk);
    endtask : move
endmodule : pins_model

//--- bench/test_touch_probe_latch_control.sv
// Testbench for the probe latch block: APB accesses against expected register values.
// Assumes the pins model drives probe pins and position.
`timescale 1ns/100ps
`include "probe_latch_map.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module test_touch_probe_latch_control
    import probe_latch_pkg::*;
;
    localparam logic [15:0] ctl = `PLC_IDX_CTRL, sts = `PLC_IDX_STAT, p1r = `PLC_IDX_P1_RISE,
        p2r = `PLC_IDX_P2_RISE, p2f = `PLC_IDX_P2_FALL, ist = `PLC_IDX_IRQ_ST, imk = `PLC_IDX_IRQ_MSK;
    logic CORE_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, HOMING_ACTIVE = 1'b0;
    logic [17:0] PADDR = 18'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA, POSITION, q;
    logic [3:0]  PSTRB = 4'hf;
    logic        PREADY, PSLVERR, IRQ, PROBE_ONE_INPUT, PROBE_TWO_INPUT, ENC_ZERO_PULSE, e;
    int          tests_run = 0, miscompares = 0;

    initial forever #4 CORE_CLK = ~CORE_CLK;

    touch_probe_latch_control i_touch_probe_latch_control (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PROBE_ONE_INPUT(PROBE_ONE_INPUT), .PROBE_TWO_INPUT(PROBE_TWO_INPUT),
        .ENC_ZERO_PULSE(ENC_ZERO_PULSE), .HOMING_ACTIVE(HOMING_ACTIVE), .POSITION(POSITION), .IRQ(IRQ));
    pins_model i_pins_model (.clk(CORE_CLK), .probe_one(PROBE_ONE_INPUT), .probe_two(PROBE_TWO_INPUT),
        .zero_pulse(ENC_ZERO_PULSE), .position(POSITION));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {idx, 2'b00};
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        // Waits as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge CORE_CLK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic rd(input logic [15:0] idx, input logic [31:0] x, input logic [31:0] m = 32'hffff_ffff);
        apb(1'b0, idx, 32'h0);
        `CHK(q & m, x)
    endtask : rd

    initial begin
        repeat (16) @(posedge CORE_CLK);
        RST <= 1'b0;
        rd(ctl, 32'h0);
        rd(sts, 32'h0);
        for (int i = 0; i < 4; i++) rd(16'(p1r + i), 32'h0);
        rd(imk, 32'h0);
        apb(1'b1, 16'h60ff, 32'h0);
        `CHK(e, 1'b1)
        apb(1'b1, ctl, 32'h0001_ffff);
        rd(ctl, 32'h0000_ffff);
        apb(1'b1, p1r, 32'h1234);
        rd(p1r, 32'h0);
        // Single rising capture with reserved bits set; disable first so the source reloads
        apb(1'b1, ctl, 32'h0);
        apb(1'b1, ctl, 32'h00d9);
        i_pins_model.move(0, 1'b1, 32'hfff0_1234);
        rd(p1r, 32'hfff0_1234);
        rd(sts, 32'h0003);
        i_pins_model.move(0, 1'b0, 32'h55);
        rd(sts, 32'h0003);
        i_pins_model.move(0, 1'b1, 32'h66);
        rd(p1r, 32'hfff0_1234);
        i_pins_model.move(0, 1'b0, 32'h0);
        // Probe two continuous on both edges
        apb(1'b1, ctl, 32'h3300);
        rd(sts, 32'h0, 32'h00ff);
        i_pins_model.move(1, 1'b1, 32'ha1);
        i_pins_model.move(1, 1'b0, 32'ha2);
        i_pins_model.move(1, 1'b1, 32'ha3);
        rd(p2r, 32'ha3);
        rd(p2f, 32'ha2);
        rd(sts, 32'h8700);
        apb(1'b1, ctl, 32'h2300);
        rd(sts, 32'h0500, 32'h0700);
        i_pins_model.move(1, 1'b0, 32'h0);
        // Zero pulse source, then a source change while continuous
        apb(1'b1, ctl, 32'h0017);
        i_pins_model.move(0, 1'b1, 32'hb1);
        rd(sts, 32'h0001, 32'h0007);
        i_pins_model.move(0, 1'b0, 32'h0);
        i_pins_model.move(2, 1'b1, 32'hb2);
        i_pins_model.move(2, 1'b0, 32'h0);
        rd(p1r, 32'hb2);
        apb(1'b1, ctl, 32'h0013);
        i_pins_model.move(2, 1'b1, 32'hb3);
        i_pins_model.move(2, 1'b0, 32'h0);
        rd(p1r, 32'hb3);
        i_pins_model.move(0, 1'b1, 32'hb4);
        rd(p1r, 32'hb4);
        // Interrupt: clear, raise, mask, unmask, clear
        apb(1'b1, ist, 32'hf);
        rd(ist, 32'h0);
        `CHK(IRQ, 1'b0)
        apb(1'b1, imk, 32'h1);
        i_pins_model.move(0, 1'b0, 32'h0);
        i_pins_model.move(0, 1'b1, 32'hc1);
        `CHK(IRQ, 1'b1)
        apb(1'b1, imk, 32'h0);
        rd(ist, 32'h1);
        `CHK(IRQ, 1'b0)
        apb(1'b1, imk, 32'h1);
        rd(ist, 32'h1);
        `CHK(IRQ, 1'b1)
        apb(1'b1, ist, 32'h1);
        rd(ist, 32'h0);
        `CHK(IRQ, 1'b0)
        // Probe two on the zero pulse in single mode, then probe one falling
        apb(1'b1, ctl, 32'h1500);
        i_pins_model.move(2, 1'b1, 32'hd1);
        i_pins_model.move(2, 1'b0, 32'h0);
        i_pins_model.move(2, 1'b1, 32'hd2);
        rd(p2r, 32'hd1);
        rd(sts, 32'h0300, 32'h0700);
        i_pins_model.move(2, 1'b0, 32'h0);
        apb(1'b1, ctl, 32'h0021);
        i_pins_model.move(0, 1'b0, 32'he1);
        rd(16'(p1r + 1), 32'he1);
        // Homing switches probe one off
        apb(1'b1, ctl, 32'h0011);
        HOMING_ACTIVE <= 1'b1;
        rd(ctl, 32'h0010);
        rd(sts, 32'h0, 32'h0001);
        HOMING_ACTIVE <= 1'b0;
        stop_test();
    end

    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule : test_touch_probe_latch_control

bind touch_probe_latch_control touch_probe_latch_control_props i_touch_probe_latch_control_props (
    .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PROBE_ONE_INPUT(PROBE_ONE_INPUT), .PROBE_TWO_INPUT(PROBE_TWO_INPUT), .ENC_ZERO_PULSE(ENC_ZERO_PULSE),
    .HOMING_ACTIVE(HOMING_ACTIVE), .POSITION(POSITION), .IRQ(IRQ));
